// File: design/sar_adc_pkg.sv
// Shared constants and types for the converter sequencer
package sar_adc_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_MODE       = 16'hff6c;
  localparam logic [15:0] ADDR_CHANNEL    = 16'hff6d;
  localparam logic [15:0] ADDR_FAIL_MODE  = 16'hff6e;
  localparam logic [15:0] ADDR_THRESHOLD  = 16'hff6f;
  localparam logic [15:0] ADDR_RESULT_LO  = 16'hff1a;
  localparam logic [15:0] ADDR_RESULT_HI  = 16'hff1b;

  // Mode register fields
  localparam int MODE_RUN_BIT    = 7;
  localparam int MODE_SCAN_BIT   = 6;
  localparam int MODE_SPEED_HI   = 5;
  localparam int MODE_SPEED_LO   = 1;
  localparam int MODE_BOOST_BIT  = 0;

  // Channel register fields
  localparam int CHAN_EDGE_HI    = 7;
  localparam int CHAN_EDGE_LO    = 6;
  localparam int CHAN_TRG_BIT    = 5;
  localparam int CHAN_SRC_BIT    = 4;
  localparam int CHAN_FIELD_HI   = 2;

  // Fail compare mode register fields
  localparam int FAIL_EN_BIT     = 7;
  localparam int FAIL_POL_BIT    = 6;

  // Values after reset
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [9:0] RESET_APPROX     = 10'h000;

  // Approximation constants
  localparam logic [9:0] APPROX_FIRST     = 10'h200;
  localparam logic [3:0] MSB_POS          = 4'h9;
  localparam int         CONV_STEPS       = 12;
  localparam int         COMPARE_STEPS    = 10;

  // Edge select encodings
  localparam logic [1:0] EDGE_NONE        = 2'h0;
  localparam logic [1:0] EDGE_FALL        = 2'h1;
  localparam logic [1:0] EDGE_RISE        = 2'h2;
  localparam logic [1:0] EDGE_BOTH        = 2'h3;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_SAMPLE, ST_CONVERT} seq_state_t;

  // Base conversion length in converter clock units per speed field
  function automatic int conv_base(input logic [4:0] speed);
    int base;
    case (speed)
      5'h01:   base = 96;
      5'h05:   base = 72;
      5'h09:   base = 48;
      5'h0d:   base = 24;
      5'h11:   base = 224;
      5'h15:   base = 168;
      5'h19:   base = 112;
      5'h1d:   base = 56;
      5'h02:   base = 72;
      5'h06:   base = 54;
      5'h0a:   base = 36;
      5'h0e:   base = 18;
      default: base = 96;
    endcase
    return base;
  endfunction

endpackage

// File: design/sar_adc_sequencer_powerfail.sv
// Successive-approximation converter sequencer with fail-threshold compare
//
// Behaviour
// - Polarity 1 with compare on: interrupt only if upper result byte below threshold.
// - Threshold compares against result bits 9..2; bits 1..0 ignored.
// - Threshold register is eight bits, read/write, zero after reset.
// - Result reads left-justified, code times 64, low six bits zero.
// - Sample selected input for fixed time, then hold until conversion ends.
// - First trial sets bit 9 against half reference.
// - Bits 8 to 0 trial-set in turn, kept when input at or above tap.
// - After ten decisions, result latched and interrupt may be raised together.
// - Software trigger: run starts conversion, repeating until run cleared.
// - Config register write aborts conversion; software mode restarts at once.
// - External trigger: after run, wait for edge chosen by edge bits.
// - External trigger: wait again after each select-mode result or scan pass; edges during conversion ignored.
// - Hardware trigger: config write aborts conversion, then waits for trigger.
// - Timer trigger starts conversion; timer trigger during conversion restarts it.
// - Select mode converts only the named channel, interrupt per fail settings.
// - Scan mode converts inputs 0 up to named channel, interrupt per fail settings after each.
// - Scan with hardware trigger: whole range once per trigger, then wait.
// - Scan abort by write or trigger restarts from input 0.
// - Clearing run stops conversion; setting it again restarts.
// - Writes to fail mode or threshold register flag a bus wait cycle.
// - Compare off: interrupt on every result; on: gated by compare.
// - Polarity 0 with compare on: interrupt only if upper byte at or above threshold.
// - Edge bits: 00 none, 01 falling, 10 rising, 11 both.
// - Three-bit channel field names one input or top of scan range.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module sar_adc_sequencer_powerfail
  import sar_adc_pkg::*;
#(
  parameter int CONV_SCALE = 4
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [7:0]  rd_data_o,
  output logic             bus_wait_o,
  // Trigger inputs
  input  wire logic        ext_trigger_pin_i,
  input  wire logic        timer_trigger_event_i,
  // Analog front end
  input  wire logic        cmp_ge_i,
  output logic      [2:0]  channel_o,
  output logic             sample_o,
  output logic      [9:0]  tap_o,
  output logic             ref_boost_on_o,
  // Conversion done
  output logic             conv_done_irq_o
);

  typedef struct packed {
    seq_state_t  state;
    logic        conv_run;
    logic        scan_enable;
    logic [4:0]  speed;
    logic        ref_boost_on;
    logic [1:0]  trigger_edge;
    logic        hw_trigger_select;
    logic        trigger_source;
    logic [2:0]  channel_field;
    logic        fail_compare_enable;
    logic        fail_compare_polarity;
    logic [7:0]  fail_threshold;
    logic [9:0]  conv_result;
    logic [9:0]  approx_register;
    logic [3:0]  bit_pos;
    logic [11:0] cnt;
    logic [2:0]  cur_ch;
    logic        sampling;
    logic        done;
    logic        irq;
    logic        bus_wait;
    logic [7:0]  rd_data;
    logic [2:0]  trig_sync;
    logic [1:0]  cmp_sync;
  } adc_state_t;

  adc_state_t cur;
  adc_state_t next;

  // Phase lengths from the speed field
  int         base_len;
  int         step_int;
  logic [11:0] step_len;
  logic [11:0] sample_len;

  always_comb begin
    base_len   = conv_base(cur.speed) * CONV_SCALE;
    step_int   = base_len / CONV_STEPS;
    step_len   = 12'(step_int);
    sample_len = 12'(base_len - COMPARE_STEPS * step_int);
  end

  // Decode and trigger helpers
  logic       cfg_wr;
  logic       busy;
  logic       ext_rise;
  logic       ext_fall;
  logic       edge_hit;
  logic       hw_trig;
  logic       last_ch;
  logic [2:0] first_ch;
  logic [9:0] fin;
  logic       pass;

  // Next-state logic
  always_comb begin
    next          = cur;
    next.done     = 1'b0;
    next.irq      = 1'b0;
    next.bus_wait = 1'b0;
    next.rd_data  = RESET_BYTE;
    next.trig_sync = {cur.trig_sync[1:0], ext_trigger_pin_i};
    next.cmp_sync  = {cur.cmp_sync[0], cmp_ge_i};
    fin  = cur.approx_register;
    pass = 1'b0;

    cfg_wr = wr_en_i && (addr_i == ADDR_MODE || addr_i == ADDR_CHANNEL ||
                         addr_i == ADDR_FAIL_MODE || addr_i == ADDR_THRESHOLD);
    busy   = (cur.state == ST_SAMPLE) || (cur.state == ST_CONVERT);

    // Register writes
    if (wr_en_i) begin
      case (addr_i)
        ADDR_MODE: begin
          next.conv_run     = wr_data_i[MODE_RUN_BIT];
          next.scan_enable  = wr_data_i[MODE_SCAN_BIT];
          next.speed        = wr_data_i[MODE_SPEED_HI:MODE_SPEED_LO];
          next.ref_boost_on = wr_data_i[MODE_BOOST_BIT];
        end
        ADDR_CHANNEL: begin
          next.trigger_edge      = wr_data_i[CHAN_EDGE_HI:CHAN_EDGE_LO];
          next.hw_trigger_select = wr_data_i[CHAN_TRG_BIT];
          next.trigger_source    = wr_data_i[CHAN_SRC_BIT];
          next.channel_field     = wr_data_i[CHAN_FIELD_HI:0];
        end
        ADDR_FAIL_MODE: begin
          next.fail_compare_enable   = wr_data_i[FAIL_EN_BIT];
          next.fail_compare_polarity = wr_data_i[FAIL_POL_BIT];
        end
        ADDR_THRESHOLD: next.fail_threshold = wr_data_i;
        default: ;
      endcase
    end
    if (cfg_wr) begin
      next.bus_wait = 1'b1;
    end

    // Register reads, data in the following cycle
    if (rd_en_i) begin
      case (addr_i)
        ADDR_MODE:      next.rd_data = {cur.conv_run, cur.scan_enable, cur.speed,
                                        cur.ref_boost_on};
        ADDR_CHANNEL:   next.rd_data = {cur.trigger_edge, cur.hw_trigger_select,
                                        cur.trigger_source, 1'b0, cur.channel_field};
        ADDR_FAIL_MODE: next.rd_data = {cur.fail_compare_enable,
                                        cur.fail_compare_polarity, 6'h00};
        ADDR_THRESHOLD: next.rd_data = cur.fail_threshold;
        ADDR_RESULT_LO: next.rd_data = {cur.conv_result[1:0], 6'h00};
        ADDR_RESULT_HI: next.rd_data = cur.conv_result[9:2];
        default:        next.rd_data = RESET_BYTE;
      endcase
      if (addr_i == ADDR_RESULT_LO || addr_i == ADDR_RESULT_HI) begin
        next.bus_wait = 1'b1;
      end
    end

    // Trigger detection on the synchronised pin
    ext_rise = cur.trig_sync[1] && !cur.trig_sync[2];
    ext_fall = !cur.trig_sync[1] && cur.trig_sync[2];
    case (cur.trigger_edge)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_FALL: edge_hit = ext_fall;
      EDGE_RISE: edge_hit = ext_rise;
      EDGE_BOTH: edge_hit = ext_rise || ext_fall;
      default:   edge_hit = 1'b0;
    endcase
    hw_trig  = cur.hw_trigger_select &&
               (cur.trigger_source ? timer_trigger_event_i : edge_hit);
    first_ch = next.scan_enable ? 3'h0 : next.channel_field;
    last_ch  = !cur.scan_enable || (cur.cur_ch == cur.channel_field);

    // Sequencer
    if (!next.conv_run) begin
      next.state = ST_IDLE;
    end else if (cur.state == ST_IDLE || (cfg_wr && busy)) begin
      next.cur_ch = first_ch;
      next.cnt    = 12'h000;
      next.state  = next.hw_trigger_select ? ST_WAIT_TRIG : ST_SAMPLE;
    end else if (busy && hw_trig && cur.trigger_source) begin
      next.cur_ch = first_ch;
      next.cnt    = 12'h000;
      next.state  = ST_SAMPLE;
    end else begin
      case (cur.state)
        ST_WAIT_TRIG: begin
          if (hw_trig) begin
            next.cur_ch = first_ch;
            next.cnt    = 12'h000;
            next.state  = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (cur.cnt == sample_len - 12'h001) begin
            next.cnt             = 12'h000;
            next.state           = ST_CONVERT;
            next.bit_pos         = MSB_POS;
            next.approx_register = APPROX_FIRST;
          end else begin
            next.cnt = cur.cnt + 12'h001;
          end
        end
        ST_CONVERT: begin
          if (cur.cnt == step_len - 12'h001) begin
            next.cnt = 12'h000;
            fin[cur.bit_pos] = cur.cmp_sync[1];
            next.approx_register = fin;
            if (cur.bit_pos == 4'h0) begin
              next.conv_result = fin;
              next.done        = 1'b1;
              if (!cur.fail_compare_enable) begin
                pass = 1'b1;
              end else if (cur.fail_compare_polarity) begin
                pass = fin[9:2] < cur.fail_threshold;
              end else begin
                pass = fin[9:2] >= cur.fail_threshold;
              end
              next.irq = pass;
              if (last_ch) begin
                next.cur_ch = cur.scan_enable ? 3'h0 : cur.channel_field;
                next.state  = cur.hw_trigger_select ? ST_WAIT_TRIG : ST_SAMPLE;
              end else begin
                next.cur_ch = cur.cur_ch + 3'h1;
                next.state  = ST_SAMPLE;
              end
            end else begin
              next.bit_pos = cur.bit_pos - 4'h1;
              next.approx_register[cur.bit_pos - 4'h1] = 1'b1;
            end
          end else begin
            next.cnt = cur.cnt + 12'h001;
          end
        end
        default: next.state = ST_IDLE;
      endcase
    end
    next.sampling = (next.state == ST_SAMPLE);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur                 <= '0;
      cur.state           <= ST_IDLE;
      cur.fail_threshold  <= RESET_BYTE;
      cur.approx_register <= RESET_APPROX;
    end else begin
      cur <= next;
    end
  end

  // Outputs
  assign rd_data_o       = cur.rd_data;
  assign bus_wait_o      = cur.bus_wait;
  assign channel_o       = cur.cur_ch;
  assign sample_o        = cur.sampling;
  assign tap_o           = cur.approx_register;
  assign ref_boost_on_o  = cur.ref_boost_on;
  assign conv_done_irq_o = cur.irq;

  // Checks
  threshold_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> cur.fail_threshold == 8'h00) else $error("threshold not cleared");
  pol_low_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done_irq_o && cur.fail_compare_enable && cur.fail_compare_polarity
    |-> cur.conv_result[9:2] < cur.fail_threshold) else $error("irq despite result above");
  pol_high_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.done && cur.fail_compare_enable && !cur.fail_compare_polarity
    |-> conv_done_irq_o == (cur.conv_result[9:2] >= cur.fail_threshold))
    else $error("polarity zero gating wrong");
  compare_off_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.done && !cur.fail_compare_enable |-> conv_done_irq_o) else $error("missing irq");
  result_low_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rd_en_i) && $past(addr_i) == ADDR_RESULT_LO |-> rd_data_o[5:0] == 6'h00)
    else $error("result low bits not zero");
  hold_channel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.state == ST_CONVERT && $past(cur.state) == ST_CONVERT
    |-> $stable(channel_o) && !sample_o) else $error("channel moved during hold");
  first_trial_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.state == ST_CONVERT && $past(cur.state) == ST_SAMPLE |-> tap_o == 10'h200)
    else $error("first trial wrong");
  sw_repeat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.done && !cur.hw_trigger_select && cur.conv_run && !wr_en_i
    |=> cur.state == ST_SAMPLE ##1 cur.state == ST_SAMPLE) else $error("no repeat");
  stop_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cur.conv_run && !$past(cur.conv_run) |-> cur.state == ST_IDLE && !sample_o)
    else $error("running with run clear");
  fail_write_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en_i && (addr_i == ADDR_FAIL_MODE || addr_i == ADDR_THRESHOLD) |=> bus_wait_o)
    else $error("no wait on fail register write");
  hw_wait_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.done && cur.hw_trigger_select && (channel_o == 3'h0 || !cur.scan_enable)
    && cur.conv_run && $past(cur.state) == ST_CONVERT && !$past(wr_en_i)
    |-> cur.state == ST_WAIT_TRIG || cur.state == ST_SAMPLE)
    else $error("hardware mode did not wait");

  scan_done_c:  cover property (@(posedge clk_i) cur.done && cur.scan_enable && channel_o != 3'h0);
  fail_irq_c:   cover property (@(posedge clk_i) conv_done_irq_o && cur.fail_compare_enable);
  timer_abort_c: cover property (@(posedge clk_i) busy && hw_trig && cur.trigger_source);
  ext_start_c:  cover property (@(posedge clk_i) cur.state == ST_WAIT_TRIG && edge_hit);

endmodule

// File: verification/tb_sar_adc_sequencer_powerfail.sv
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module tb_sar_adc_sequencer_powerfail;
  import sar_adc_pkg::*;

  logic        clk_i;
  logic        rst_i;
  logic [15:0] addr_i;
  logic [7:0]  wr_data_i;
  logic        wr_en_i;
  logic        rd_en_i;
  logic [7:0]  rd_data_o;
  logic        bus_wait_o;
  logic        ext_trigger_pin_i;
  logic        timer_trigger_event_i;
  logic        cmp_ge_i;
  logic [2:0]  channel_o;
  logic        sample_o;
  logic [9:0]  tap_o;
  logic        ref_boost_on_o;
  logic        conv_done_irq_o;
  logic [9:0]  target;
  logic        bw;
  logic [7:0]  d;
  int          err_total;
  int          samples_checked;
  int          c;

  // Scale 3: 288-cycle conversions, 24-cycle steps
  sar_adc_sequencer_powerfail #(.CONV_SCALE(3)) i_sar_adc_sequencer_powerfail (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .bus_wait_o(bus_wait_o),
    .ext_trigger_pin_i(ext_trigger_pin_i), .timer_trigger_event_i(timer_trigger_event_i),
    .cmp_ge_i(cmp_ge_i), .channel_o(channel_o), .sample_o(sample_o), .tap_o(tap_o),
    .ref_boost_on_o(ref_boost_on_o), .conv_done_irq_o(conv_done_irq_o));

  // Clock, 5 ns period
  always #2.5 clk_i = ~clk_i;

  // Ideal comparator for the held input
  always @(posedge clk_i) begin
    cmp_ge_i <= (target >= tap_o);
  end

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    #1 bw = bus_wait_o;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 v = rd_data_o;
  endtask

  // Count interrupt pulses over a span of cycles
  task automatic count_irq(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 if (conv_done_irq_o === 1'b1) cnt++;
    end
  endtask

  task automatic wait_sample(input logic lvl);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      #1 if (sample_o === lvl) break;
    end
  endtask

  task automatic t_regs;
    rd(ADDR_THRESHOLD, d);
    chk_v(10'(d), 10'h000);
    wr(ADDR_THRESHOLD, 8'ha5);
    chk_v(10'(bw), 10'h001);
    rd(ADDR_THRESHOLD, d);
    chk_v(10'(d), 10'h0a5);
    wr(ADDR_FAIL_MODE, 8'hc0);
    chk_v(10'(bw), 10'h001);
    rd(16'h0000, d);
    chk_v(10'(d), 10'h000);
    wr(ADDR_FAIL_MODE, 8'h00);
    wr(ADDR_THRESHOLD, 8'h00);
  endtask

  task automatic t_conv;
    logic [9:0] codes [2];
    codes = '{10'h2b7, 10'h14a};
    // Boost on first, then settle one microsecond before run
    wr(ADDR_MODE, 8'h03);
    chk_v(10'(ref_boost_on_o), 10'h001);
    repeat (200) @(posedge clk_i);
    foreach (codes[k]) begin
      target = codes[k];
      wr(ADDR_MODE, 8'h83);
      wait_sample(1'b0);
      chk_v(tap_o, 10'h200);
      chk_v(10'(channel_o), 10'h000);
      count_irq(260, c);
      chk_n(c, 1);
      rd(ADDR_RESULT_HI, d);
      chk_v(10'(d), {2'h0, target[9:2]});
      rd(ADDR_RESULT_LO, d);
      chk_v(10'(d), {2'h0, target[1:0], 6'h00});
      count_irq(300, c);
      chk_n(c, 1);
      wr(ADDR_MODE, 8'h03);
      count_irq(400, c);
      chk_n(c, 0);
    end
  endtask

  task automatic t_fail;
    logic [7:0] fm [5];
    logic [7:0] th [5];
    int         ex [5];
    fm = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'h00};
    th = '{8'had, 8'hae, 8'hae, 8'had, 8'hff};
    ex = '{1, 0, 1, 0, 1};
    target = 10'h2b7;
    foreach (fm[k]) begin
      wr(ADDR_FAIL_MODE, fm[k]);
      wr(ADDR_THRESHOLD, th[k]);
      wr(ADDR_MODE, 8'h83);
      count_irq(400, c);
      chk_n(c, ex[k]);
      wr(ADDR_MODE, 8'h03);
    end
    wr(ADDR_FAIL_MODE, 8'h00);
  endtask

  // Timer pulse mid-conversion restarts it
  task automatic t_timer;
    wr(ADDR_CHANNEL, 8'h30);
    wr(ADDR_MODE, 8'h83);
    count_irq(400, c);
    chk_n(c, 0);
    repeat (2) begin
      @(posedge clk_i);
      timer_trigger_event_i <= 1'b1;
      @(posedge clk_i);
      timer_trigger_event_i <= 1'b0;
      count_irq(100, c);
    end
    count_irq(150, c);
    chk_n(c, 0);
    count_irq(100, c);
    chk_n(c, 1);
    wr(ADDR_MODE, 8'h03);
  endtask

  // Rising edge selected; extra edge mid-run ignored
  task automatic t_ext;
    wr(ADDR_CHANNEL, 8'ha0);
    wr(ADDR_MODE, 8'h83);
    count_irq(20, c);
    ext_trigger_pin_i <= 1'b1;
    count_irq(100, c);
    ext_trigger_pin_i <= 1'b0;
    count_irq(10, c);
    ext_trigger_pin_i <= 1'b1;
    count_irq(250, c);
    chk_n(c, 1);
    ext_trigger_pin_i <= 1'b0;
    count_irq(400, c);
    chk_n(c, 0);
    // Falling edge selected while waiting; rising edge must not start
    wr(ADDR_CHANNEL, 8'h60);
    ext_trigger_pin_i <= 1'b1;
    count_irq(50, c);
    chk_n(c, 0);
    ext_trigger_pin_i <= 1'b0;
    count_irq(320, c);
    chk_n(c, 1);
    wr(ADDR_MODE, 8'h03);
  endtask

  task automatic t_scan;
    logic [2:0] seq [4];
    seq = '{3'h0, 3'h1, 3'h2, 3'h0};
    wr(ADDR_CHANNEL, 8'h02);
    wr(ADDR_MODE, 8'hc3);
    foreach (seq[k]) begin
      wait_sample(1'b1);
      chk_v(10'(channel_o), 10'(seq[k]));
      wait_sample(1'b0);
    end
    wait_sample(1'b1);
    wr(ADDR_CHANNEL, 8'h02);
    count_irq(2, c);
    chk_v(10'(channel_o), 10'h000);
    wr(ADDR_MODE, 8'h03);
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  // Main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    addr_i = 16'h0000;
    wr_data_i = 8'h00;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    ext_trigger_pin_i = 1'b0;
    timer_trigger_event_i = 1'b0;
    cmp_ge_i = 1'b0;
    target = 10'h000;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_conv();
    t_fail();
    t_timer();
    t_ext();
    t_scan();
    stop_test();
  end
endmodule
